// ==== include/rtcifc_pkg.sv ====
/*
  constants for the rtc interrupt flag and control block: register offsets,
  bit positions and reset values. assumes a 32-bit apb slave, one word per register.
*/
package rtcifc_pkg;
  // printed offsets 0xd and 0x7e are not word multiples: indices, byte addr = 4*index
  localparam logic [7:0]  IDX_CTRL     = 8'h0b;  // update and format control
  localparam logic [7:0]  IDX_FLAGS    = 8'h0c;
  localparam logic [7:0]  IDX_VALID    = 8'h0d;
  localparam logic [7:0]  IDX_PWR      = 8'h7e;
  localparam logic [7:0]  IDX_RATE     = 8'h0a;  // rate select and date alarm enable
  localparam logic [7:0]  IDX_STATUS   = 8'h0f;  // alarm time bytes, with live update busy on read
  // update_and_format_control bits
  localparam int          B_INHIBIT    = 7;
  localparam int          B_PIE        = 6;
  localparam int          B_AIE        = 5;
  localparam int          B_UIE        = 4;
  localparam int          B_BIN        = 2;
  localparam int          B_H24        = 1;
  // flag bits
  localparam int          B_SUMMARY_IRQ_FLAG       = 7;
  localparam int          B_PF         = 6;
  localparam int          B_UF         = 5;
  localparam int          B_AF         = 4;
  // validity register
  localparam int          B_VRT        = 7;
  localparam logic [5:0]  DATE_DC      = 6'h30;  // top two bits set: don't care
  // power control bits
  localparam int          B_REM        = 0;
  localparam int          B_OFF        = 1;
  localparam int          B_WAKE       = 2;
  localparam int          B_XCAP       = 7;
  localparam logic [7:0]  PWR_MASK     = 8'h87;
  localparam logic [7:0]  PWR_RST      = 8'h00;
  // rate register (IDX_RATE) bits and the alarm time byte don't-care mask
  localparam int          B_DATE_EN    = 4;
  localparam logic [7:0]  TIME_DC_MASK = 8'hc0;
endpackage

// ==== verilog/rtcifc_core.sv ====
/*
  rtc interrupt enable, flag and control logic with an apb slave.
  assumes the time base, update engine and time counters sit outside and
  present their events and bytes on plain ports in the pclk domain;
  battery_por_n and standby_supply come from outside; only standby_supply is synchronised.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module rtcifc_core
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        battery_por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] divider_taps,
  input  wire logic        update_busy,
  input  wire logic        update_end,
  input  wire logic        second_tick,
  input  wire logic [7:0]  time_sec,
  input  wire logic [7:0]  time_min,
  input  wire logic [7:0]  time_hour,
  input  wire logic [5:0]  time_date,
  input  wire logic        battery_low,
  input  wire logic        standby_supply,
  output logic             update_inhibit,
  output logic             binary_format_sel,
  output logic             hour24_sel,
  output logic             crystal_load_sel,
  output logic [7:0]       alarm_sec,
  output logic [7:0]       alarm_min,
  output logic [7:0]       alarm_hour,
  output logic             irq_out_n,
  output logic             power_on_request_n_o,
  output logic             power_on_request_n_oe
);
  // state on the bus reset
  typedef struct packed {
    logic       periodic_irq_enable;
    logic       alarm_irq_enable;
    logic       update_done_irq_enable;
    logic [3:0] rate;
    logic       date_en;
    logic       periodic_flag;
    logic       update_done_flag;
    logic       alarm_flag;
    logic       time_valid_bit;
    logic [7:0] a_sec;
    logic [7:0] a_min;
    logic [7:0] a_hour;
    logic       tap_d;
    logic [2:0] sb_sync;
    logic       missed_alarm;
    logic       wake_pend;
    logic       req_low;
    logic       req_drive;
    logic [31:0] rdata;
  } rtcifc_state_t;

  // battery domain state kept apart: it survives the bus reset
  // inhibit, format bits and date alarm live here too, since the bus reset must not touch them
  typedef struct packed {
    logic       inhibit;
    logic       bin;
    logic       h24;
    logic [5:0] date_alarm;
    logic [7:0] pwr;
  } rtcifc_batt_t;

  rtcifc_state_t st_ff, nxt_st;
  rtcifc_batt_t  bt_ff, nxt_bt;

  function automatic logic byte_match(input logic [7:0] t, input logic [7:0] a);
    byte_match = ((a & rtcifc_pkg::TIME_DC_MASK) == rtcifc_pkg::TIME_DC_MASK) || (a == t);
  endfunction

  logic [7:0] idx;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       setup_rd;
  logic       mapped;
  logic       tap;
  logic       irq_sum;
  logic       sb_on;
  logic       sb_prev;
  logic       alarm_hit;

  assign idx    = paddr[9:2];
  assign acc    = psel && penable;
  assign wr     = acc && pwrite && pstrb[0];
  assign rd     = acc && !pwrite;
  // read word is latched in the setup cycle so it stands at the access edge
  assign setup_rd = psel && !penable && !pwrite;
  assign mapped = (idx == rtcifc_pkg::IDX_CTRL) || (idx == rtcifc_pkg::IDX_FLAGS) ||
                  (idx == rtcifc_pkg::IDX_VALID) || (idx == rtcifc_pkg::IDX_PWR) ||
                  (idx == rtcifc_pkg::IDX_RATE) || (idx == rtcifc_pkg::IDX_STATUS);

  assign tap     = (st_ff.rate == 4'h0) ? 1'b0 : divider_taps[st_ff.rate];
  assign irq_sum = (st_ff.periodic_flag && st_ff.periodic_irq_enable) ||
                   (st_ff.alarm_flag && st_ff.alarm_irq_enable) ||
                   (st_ff.update_done_flag && st_ff.update_done_irq_enable);
  // only synchroniser stages two and three are looked at
  assign sb_on   = st_ff.sb_sync[1] & st_ff.sb_sync[2];
  assign sb_prev = st_ff.sb_sync[1] | st_ff.sb_sync[2];

  assign alarm_hit = second_tick && !bt_ff.inhibit &&
                     byte_match(time_sec, st_ff.a_sec) &&
                     byte_match(time_min, st_ff.a_min) &&
                     byte_match(time_hour, st_ff.a_hour) &&
                     (!st_ff.date_en || bt_ff.date_alarm == time_date ||
                      (bt_ff.date_alarm & rtcifc_pkg::DATE_DC) == rtcifc_pkg::DATE_DC);

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.tap_d   = tap;
    nxt_st.sb_sync = {st_ff.sb_sync[1:0], standby_supply};
    nxt_st.rdata   = 32'h0000_0000;

    // flag register read: flags seen this access clear, new events set after
    // only bits that the latched word showed as set are cleared; later ones are kept
    if (rd && idx == rtcifc_pkg::IDX_FLAGS)
    begin
      if (st_ff.rdata[rtcifc_pkg::B_PF])
        nxt_st.periodic_flag = 1'b0;

      if (st_ff.rdata[rtcifc_pkg::B_UF])
        nxt_st.update_done_flag = 1'b0;

      if (st_ff.rdata[rtcifc_pkg::B_AF])
        nxt_st.alarm_flag = 1'b0;
    end
    // set wins over the clear; sampled data already registered in rdata
    if (tap && !st_ff.tap_d)
      nxt_st.periodic_flag = 1'b1;
    if (update_end && !bt_ff.inhibit)
      nxt_st.update_done_flag = 1'b1;
    if (alarm_hit)
      nxt_st.alarm_flag = 1'b1;

    if (battery_low)
      nxt_st.time_valid_bit = 1'b0;
    else if (rd && idx == rtcifc_pkg::IDX_VALID)
      nxt_st.time_valid_bit = 1'b1;

    if (wr)
    begin
      case (idx)
        rtcifc_pkg::IDX_CTRL:
        begin
          nxt_st.periodic_irq_enable     = pwdata[rtcifc_pkg::B_PIE];
          nxt_st.alarm_irq_enable     = pwdata[rtcifc_pkg::B_AIE];
          nxt_st.update_done_irq_enable     = pwdata[rtcifc_pkg::B_UIE];
          if (pwdata[rtcifc_pkg::B_INHIBIT] && !bt_ff.inhibit)
            nxt_st.update_done_irq_enable = 1'b0;
        end
        rtcifc_pkg::IDX_RATE:
        begin
          nxt_st.rate    = pwdata[3:0];
          nxt_st.date_en = pwdata[rtcifc_pkg::B_DATE_EN];
        end
        rtcifc_pkg::IDX_STATUS:
        begin
          nxt_st.a_sec  = pwdata[7:0];
          nxt_st.a_min  = pwdata[15:8];
          nxt_st.a_hour = pwdata[23:16];
        end
        default:
          nxt_st.rate = st_ff.rate;  // flags register is read-only
      endcase
    end

    if (setup_rd)
    begin
      case (idx)
        rtcifc_pkg::IDX_CTRL:
          nxt_st.rdata = {24'h0, bt_ff.inhibit, st_ff.periodic_irq_enable, st_ff.alarm_irq_enable, st_ff.update_done_irq_enable,
                          1'b0, bt_ff.bin, bt_ff.h24, 1'b0};
        rtcifc_pkg::IDX_FLAGS:
          nxt_st.rdata = {24'h0, irq_sum, st_ff.periodic_flag, st_ff.update_done_flag,
                          st_ff.alarm_flag, 4'h0};
        rtcifc_pkg::IDX_VALID:
          nxt_st.rdata = {24'h0, st_ff.time_valid_bit, 1'b0,
                          (st_ff.date_en && !update_busy) ? bt_ff.date_alarm : 6'h00};
        rtcifc_pkg::IDX_PWR:
          nxt_st.rdata = {24'h0, bt_ff.pwr};
        rtcifc_pkg::IDX_RATE:
          nxt_st.rdata = {27'h0, st_ff.date_en, st_ff.rate};
        rtcifc_pkg::IDX_STATUS:
          nxt_st.rdata = {7'h00, update_busy, st_ff.a_hour, st_ff.a_min, st_ff.a_sec};
        default:
          nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // alarm missed while standby absent is remembered until it returns
    if (alarm_hit && !sb_prev && bt_ff.pwr[rtcifc_pkg::B_REM])
      nxt_st.missed_alarm = 1'b1;
    if (sb_on && st_ff.missed_alarm)
    begin
      nxt_st.missed_alarm = 1'b0;
      nxt_st.wake_pend    = 1'b1;
    end
    if (sb_on && !st_ff.req_drive && !st_ff.wake_pend)
    begin
      // standby just came up: wake or stay off
      nxt_st.req_drive = 1'b1;
      nxt_st.req_low   = bt_ff.pwr[rtcifc_pkg::B_WAKE] &&
                         !bt_ff.pwr[rtcifc_pkg::B_OFF];
    end
    if (st_ff.wake_pend)
    begin
      nxt_st.req_drive = 1'b1;
      nxt_st.req_low   = 1'b1;
    end
    if (!sb_on)
    begin
      nxt_st.req_drive = 1'b0;
      nxt_st.req_low   = 1'b0;
      nxt_st.wake_pend = 1'b0;
    end
  end

  always_comb
  begin
    nxt_bt = bt_ff;
    if (wr && idx == rtcifc_pkg::IDX_PWR)
      nxt_bt.pwr = pwdata[7:0] & rtcifc_pkg::PWR_MASK;

    // software is the only writer of these; only the battery reset reaches them, no bus reset or update logic
    if (wr && idx == rtcifc_pkg::IDX_CTRL)
    begin
      nxt_bt.inhibit = pwdata[rtcifc_pkg::B_INHIBIT];
      nxt_bt.bin     = pwdata[rtcifc_pkg::B_BIN];
      nxt_bt.h24     = pwdata[rtcifc_pkg::B_H24];
    end

    // a running update locks the date alarm; the write is dropped, not deferred
    if (wr && idx == rtcifc_pkg::IDX_VALID && !update_busy)
    begin
      nxt_bt.date_alarm = pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;  // inhibit, format and date alarm sit in the battery state
    else
      st_ff <= nxt_st;
  end

  // bus reset does not reach this one; its reset is the battery reset
  always_ff @(posedge pclk or negedge battery_por_n)
  begin
    if (!battery_por_n)
      bt_ff <= '{pwr: rtcifc_pkg::PWR_RST, default: '0};
    else
      bt_ff <= nxt_bt;
  end

  assign prdata                = st_ff.rdata;
  assign pready                = 1'b1;
  assign pslverr               = acc && !mapped;
  assign update_inhibit        = bt_ff.inhibit;
  assign binary_format_sel     = bt_ff.bin;
  assign hour24_sel            = bt_ff.h24;
  assign crystal_load_sel      = bt_ff.pwr[rtcifc_pkg::B_XCAP];
  assign alarm_sec             = st_ff.a_sec;
  assign alarm_min             = st_ff.a_min;
  assign alarm_hour            = st_ff.a_hour;
  assign irq_out_n             = !irq_sum;
  assign power_on_request_n_o  = 1'b0;
  assign power_on_request_n_oe = !(st_ff.req_drive && st_ff.req_low);
endmodule

// ==== tb/rtcifc_monitor.sv ====
/*
  port checker for rtcifc_core: bus answers, software-only control levels,
  flag read layout and summary versus irq.
  assumes the single pclk domain and indices as in rtcifc_pkg.
*/
`timescale 1ns/10ps
module rtcifc_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        battery_por_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        update_inhibit,
  input wire logic        binary_format_sel,
  input wire logic        hour24_sel,
  input wire logic        crystal_load_sel,
  input wire logic [7:0]  alarm_sec,
  input wire logic        irq_out_n,
  input wire logic        power_on_request_n_o
);
  logic [7:0] idx;
  logic       acc;
  logic       mapped;
  assign idx = paddr[9:2];
  assign acc = psel && penable && pready;
  assign mapped = idx inside {rtcifc_pkg::IDX_RATE, rtcifc_pkg::IDX_CTRL, rtcifc_pkg::IDX_FLAGS,
                              rtcifc_pkg::IDX_VALID, rtcifc_pkg::IDX_STATUS, rtcifc_pkg::IDX_PWR};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !battery_por_n);
  a_ready_tied: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped index");
  a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped index");
  a_inhibit_sw_only: assert property (!$stable(update_inhibit) |->
    $past(acc && pwrite && idx == rtcifc_pkg::IDX_CTRL)) else $error("inhibit moved alone");
  a_format_sw_only: assert property (!$stable(binary_format_sel) |->
    $past(acc && pwrite && idx == rtcifc_pkg::IDX_CTRL)) else $error("format moved alone");
  a_hour_sw_only: assert property (!$stable(hour24_sel) |->
    $past(acc && pwrite && idx == rtcifc_pkg::IDX_CTRL)) else $error("hour mode moved alone");
  a_alarm_sw_only: assert property (!$stable(alarm_sec) |->
    $past(acc && pwrite && idx == rtcifc_pkg::IDX_STATUS)) else $error("alarm byte moved");
  a_crystal_sw_only: assert property (disable iff (!presetn || !battery_por_n)
    !$stable(crystal_load_sel) |-> $past(acc && pwrite && idx == rtcifc_pkg::IDX_PWR))
    else $error("crystal select moved");
  a_flags_low_zero: assert property (acc && !pwrite && idx == rtcifc_pkg::IDX_FLAGS |->
    prdata[3:0] == 4'h0 && prdata[31:8] == 24'h0) else $error("flag read unused bits set");
  a_summary_irq: assert property (acc && !pwrite && idx == rtcifc_pkg::IDX_FLAGS |->
    prdata[7] == !$past(irq_out_n)) else $error("summary flag and irq disagree");
  a_pwr_reserved: assert property (acc && !pwrite && idx == rtcifc_pkg::IDX_PWR |->
    prdata[6:3] == 4'h0) else $error("power reserved bits set");
  a_request_low: assert property (power_on_request_n_o == 1'b0)
    else $error("power request driven high");
endmodule
bind rtcifc_core rtcifc_monitor u_mon (.pclk, .presetn, .battery_por_n, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .update_inhibit, .binary_format_sel,
  .hour24_sel, .crystal_load_sel, .alarm_sec, .irq_out_n, .power_on_request_n_o);

// ==== tb/rtcifc_core_test.sv ====
/*
  self-checking bench for rtcifc_core: apb master, event pulses, queued read checks.
  assumes read data stands at the access edge, where it is taken.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module rtcifc_core_test;
  logic        pclk, presetn, battery_por_n, psel, penable, pwrite;
  logic        update_end, second_tick, standby_supply, pready, pslverr, irq_out_n, pwr_oe;
  logic [31:0] paddr, pwdata, prdata, exp_v;
  logic [15:0] divider_taps;
  logic [7:0]  time_sec, time_min, time_hour, asec;
  logic [31:0] exp_q[$];
  int          err_total, checks_done, seed, i;
  rtcifc_core dut (.pclk(pclk), .presetn(presetn), .battery_por_n(battery_por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .divider_taps(divider_taps),
    .update_busy(1'b0), .update_end(update_end), .second_tick(second_tick),
    .time_sec(time_sec), .time_min(time_min), .time_hour(time_hour), .time_date(6'h00),
    .battery_low(1'b0), .standby_supply(standby_supply), .update_inhibit(),
    .binary_format_sel(), .hour24_sel(), .crystal_load_sel(), .alarm_sec(), .alarm_min(),
    .alarm_hour(), .irq_out_n(irq_out_n), .power_on_request_n_o(),
    .power_on_request_n_oe(pwr_oe));
  task test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_total++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d); xfer(1'b1, idx, d); endtask
  task rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, idx, 32'h0);
  endtask
  // one event pulse, then two quiet edges so flags settle
  task ev(input int k);
    @(posedge pclk);
    divider_taps <= (k == 0) ? 16'h0002 : 16'h0000;
    update_end <= (k == 1);
    second_tick <= (k == 2);
    @(posedge pclk);
    {divider_taps, update_end, second_tick} <= '0;
    repeat (2) @(posedge pclk);
  endtask
  task irqchk(input logic e);
    @(negedge pclk);
    `CHK("irq_out_n", e, irq_out_n)
  endtask
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1)
    begin
      exp_v = exp_q.size() ? exp_q.pop_front() : 32'hxxxxxxxx;
      `CHK("prdata", exp_v, prdata)
    end
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    #2500000;
    err_total++;
    test_done();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, update_end, second_tick} = '0;
    {battery_por_n, standby_supply} = 2'b11;
    {paddr, pwdata, divider_taps, time_sec, time_min, time_hour} = '0;
    {err_total, checks_done} = '0;
    seed = 74;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(rtcifc_pkg::IDX_FLAGS, 32'h0);
    wr(rtcifc_pkg::IDX_CTRL, 32'h7f);
    rd(rtcifc_pkg::IDX_CTRL, 32'h76);
    wr(rtcifc_pkg::IDX_CTRL, 32'hf6);
    rd(rtcifc_pkg::IDX_CTRL, 32'he6);
    wr(rtcifc_pkg::IDX_CTRL, 32'h0);
    wr(rtcifc_pkg::IDX_RATE, 32'h1);
    ev(0);
    irqchk(1'b1);
    rd(rtcifc_pkg::IDX_FLAGS, 32'h40);
    rd(rtcifc_pkg::IDX_FLAGS, 32'h0);
    wr(rtcifc_pkg::IDX_CTRL, 32'h40);
    ev(0);
    irqchk(1'b0);
    rd(rtcifc_pkg::IDX_FLAGS, 32'hc0);
    irqchk(1'b1);
    wr(rtcifc_pkg::IDX_CTRL, 32'h10);
    ev(1);
    irqchk(1'b0);
    rd(rtcifc_pkg::IDX_FLAGS, 32'ha0);
    // alarm: minutes and hours carry the don't-care code, seconds a random value
    asec = 8'($random(seed)) & 8'h3f;
    wr(rtcifc_pkg::IDX_STATUS, {8'h0, 8'hff, 8'hc0, asec});
    rd(rtcifc_pkg::IDX_STATUS, {8'h0, 8'hff, 8'hc0, asec});
    wr(rtcifc_pkg::IDX_CTRL, 32'h20);
    for (i = 0; i < 3; i++)
    begin
      if (i == 2)
        wr(rtcifc_pkg::IDX_CTRL, 32'h0);
      time_sec <= (i == 1) ? (asec ^ 8'h01) : asec;
      time_min <= 8'($random(seed));
      time_hour <= 8'($random(seed));
      ev(2);
      irqchk(i != 0);
      rd(rtcifc_pkg::IDX_FLAGS, (i == 0) ? 32'h90 : (i == 1) ? 32'h0 : 32'h10);
    end
    rd(8'h20, 32'h0);
    wr(rtcifc_pkg::IDX_PWR, 32'hfb);
    rd(rtcifc_pkg::IDX_PWR, 32'h83);
    wr(rtcifc_pkg::IDX_CTRL, 32'h66);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(rtcifc_pkg::IDX_PWR, 32'h83);
    rd(rtcifc_pkg::IDX_CTRL, 32'h06);
    battery_por_n <= 1'b0;
    repeat (2) @(posedge pclk);
    battery_por_n <= 1'b1;
    rd(rtcifc_pkg::IDX_PWR, 32'h0);
    wr(rtcifc_pkg::IDX_PWR, 32'h4);
    standby_supply <= 1'b0;
    repeat (6) @(posedge pclk);
    standby_supply <= 1'b1;
    for (i = 0; i < 40 && pwr_oe !== 1'b0; i++) @(posedge pclk);
    `CHK("power_on_request_n_oe", 1'b0, pwr_oe)
    repeat (3) @(posedge pclk);
    `CHK("pending reads", 0, exp_q.size())
    test_done();
  end
endmodule
